// file: core/pdf_fade.sv
/*
 * PWM dimming fade engine: fade settings registers, fade controller,
 * update-rate divider and frame-sync resync request.
 * Assumes one PWM period-end pulse per output period and a one-cycle
 * duty write strobe from the dimming register logic elsewhere.
 */
// Chosen here: the strobed register port.
`timescale 1ns/10ps

// Functional notes
// R01: Ramp off applies new duty at once; ramp on fades toward it.
// R02: Curve bit low gives logarithmic ramp, high gives linear ramp.
// R03: Each fade step is multiplied by two to the step_scale code, at most sixteen for codes above 4.
// R04: Fade rate bit 7 enables automatic resync to frame sync.
// R05: Frame resync happens only while frame_sync_on is high.
// R06: Duty updates once every one plus divider PWM periods.
// R07: Duty moves toward target by the step, clamps, then fade ends.
module pdf_fade (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire pdf_pkg::pdf_addr_t reg_addr, // Register address
    input wire pdf_pkg::pdf_data_t reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output pdf_pkg::pdf_data_t reg_rdata, // Read data, cycle after strobe
    input wire logic duty_wr, // New dimming duty strobe
    input wire pdf_pkg::pdf_duty_t duty_wdata, // New dimming duty value
    input wire logic pwm_period_end, // One pulse per PWM output period
    input wire logic frame_sync_on, // Frame sync feature enabled
    input wire logic frame_sync, // Frame sync pulse
    output pdf_pkg::pdf_duty_t duty_out, // Duty applied to the PWM
    output logic fade_busy, // Fade in progress
    output logic resync_pulse // Realign PWM counters
);
    import pdf_pkg::*;

    // ****************************************
    // Settings registers
    // ****************************************
    pdf_data_t opt_reg;
    pdf_data_t rate_reg;
    logic ramp_on;
    logic curve_select;
    logic [2:0] step_scale;
    logic auto_resync_on;
    logic [`PDF_DIV_W-1:0] update_divider;

    assign ramp_on = opt_reg[`PDF_OPT_RAMP_BIT];
    assign curve_select = opt_reg[`PDF_OPT_CURVE_BIT];
    assign step_scale = opt_reg[`PDF_OPT_SCALE_HI:`PDF_OPT_SCALE_LO];
    assign auto_resync_on = rate_reg[`PDF_RATE_RESYNC_BIT];
    assign update_divider = rate_reg[`PDF_RATE_DIV_HI:`PDF_RATE_DIV_LO];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            opt_reg <= `PDF_OPT_RESET;
            rate_reg <= `PDF_RATE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `PDF_ADDR_OPTIONS) begin
                // Unused bits 5:3 are not stored and read zero
                opt_reg <= {reg_wdata[`PDF_OPT_RAMP_BIT], reg_wdata[`PDF_OPT_CURVE_BIT],
                            3'h0, reg_wdata[`PDF_OPT_SCALE_HI:`PDF_OPT_SCALE_LO]};
            end else if (reg_addr == `PDF_ADDR_RATE) begin
                // R04: resync enable bit
                rate_reg <= reg_wdata;
            end
        end
    end

    pdf_state_t state;
    pdf_duty_t target;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= `PDF_READ_ZERO;
        end else if (reg_rd) begin
            if (reg_addr == `PDF_ADDR_OPTIONS) begin
                reg_rdata <= opt_reg;
            end else if (reg_addr == `PDF_ADDR_RATE) begin
                reg_rdata <= rate_reg;
            end else if (reg_addr == `PDF_ADDR_STATUS) begin
                reg_rdata <= pdf_data_t'(fade_busy);
            end else if (reg_addr == `PDF_ADDR_DUTY_LO) begin
                reg_rdata <= duty_out[7:0];
            end else if (reg_addr == `PDF_ADDR_DUTY_HI) begin
                reg_rdata <= pdf_data_t'(duty_out[`PDF_DUTY_W-1:8]);
            end else begin
                reg_rdata <= `PDF_READ_ZERO;
            end
        end else begin
            reg_rdata <= `PDF_READ_ZERO;
        end
    end

    // ****************************************
    // Update-rate divider
    // ****************************************
    logic [`PDF_DIV_W-1:0] div_cnt;
    logic upd;

    // R06: one update per (1 + divider) periods
    assign upd = (state == PDF_FADE) && pwm_period_end && (div_cnt == update_divider);

    always_ff @(posedge clk_sys) begin
        if (rst || duty_wr || state != PDF_FADE) begin
            div_cnt <= `PDF_DIV_RESET;
        end else if (pwm_period_end) begin
            // R06: count output periods
            div_cnt <= (div_cnt == update_divider) ? `PDF_DIV_RESET : div_cnt + `PDF_DIV_ONE;
        end
    end

    // ****************************************
    // Fade controller
    // ****************************************
    pdf_step_if sif ();

    assign sif.cur = duty_out;
    assign sif.target = target;
    assign sif.curve = curve_select;
    assign sif.scale = step_scale;

    pdf_step u_step (
        .sif(sif)
    );

    assign fade_busy = (state == PDF_FADE);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= PDF_IDLE;
            duty_out <= `PDF_DUTY_RESET;
            target <= `PDF_DUTY_RESET;
        end else if (duty_wr) begin
            // A fresh duty write restarts the fade from where it stands
            target <= duty_wdata;
            if (!ramp_on) begin
                // R01: jump directly
                duty_out <= duty_wdata;
                state <= PDF_IDLE;
            end else begin
                // R01: fade gradually
                state <= (duty_wdata != duty_out) ? PDF_FADE : PDF_IDLE;
            end
        end else begin
            case (state)
                PDF_FADE: begin
                    if (upd) begin
                        // R07: step and end at target
                        duty_out <= sif.next;
                        state <= (sif.next == target) ? PDF_IDLE : PDF_FADE;
                    end
                end
                default: begin
                    state <= PDF_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Frame resync
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            resync_pulse <= 1'b0;
        end else begin
            // R05: gated by frame_sync_on
            resync_pulse <= frame_sync && frame_sync_on && auto_resync_on;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_write_fade;
        duty_wr && ramp_on && (duty_wdata != duty_out);
    endsequence

    sequence s_lin_unit_up;
        upd && !duty_wr && curve_select && (step_scale == 3'h0) &&
            ({1'b0, target} > {1'b0, duty_out} + 11'h001);
    endsequence

    a_jump_direct: assert property (duty_wr && !ramp_on |=> // R01
        (duty_out == $past(duty_wdata)) && !fade_busy)
        else $error("Duty not applied at once with ramp off");
    a_fade_start: assert property (s_write_fade |=> fade_busy && // R01
        (duty_out == $past(duty_out)) && (target == $past(duty_wdata)))
        else $error("Fade did not start on duty write");
    // Duty write in the update cycle wins, so it is kept out of the antecedent
    a_linear_step: assert property (s_lin_unit_up |=> // R02
        duty_out == $past(duty_out) + 10'h001)
        else $error("Linear unit step wrong");
    a_scale_sixteen: assert property (upd && curve_select && (step_scale == 3'h4) && // R03
        ({1'b0, target} > {1'b0, duty_out} + 11'h010) && !duty_wr
        |=> duty_out == $past(duty_out) + 10'h010)
        else $error("Scaled step not sixteen");
    a_log_step: assert property (upd && !curve_select && (step_scale == 3'h0) && // R02
        (duty_out >= 10'h020) && ({1'b0, duty_out} > {1'b0, target} + 11'h040) && !duty_wr
        |=> duty_out == $past(duty_out) - ($past(duty_out) >> 4))
        else $error("Log step wrong");
    a_resync_gate: assert property (frame_sync && frame_sync_on && auto_resync_on // R04
        |=> resync_pulse)
        else $error("Resync not requested");
    a_resync_off: assert property (!(frame_sync && frame_sync_on) |=> !resync_pulse) // R05
        else $error("Resync without frame sync enabled");
    // Duty may only move on a write or on the counted period end
    a_update_rate: assert property (!(pwm_period_end && (div_cnt == update_divider)) && // R06
        !duty_wr |=> $stable(duty_out))
        else $error("Fade update off its period");
    a_no_overshoot: assert property (upd && !duty_wr && (duty_out < target) |=> // R07
        (duty_out <= target) && (duty_out > $past(duty_out)) &&
        (fade_busy == (duty_out != target)))
        else $error("Fade overshoot or stall");
endmodule // pdf_fade

// file: core/pdf_params.svh
/*
 * Constants for the PWM dimming fade engine: register offsets, field
 * positions, reset values and widths.
 * Assumes it is included by its bare name from the package and the bench.
 */
`ifndef PDF_PARAMS_SVH
`define PDF_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define PDF_ADDR_W 8
`define PDF_DATA_W 8
`define PDF_ADDR_OPTIONS 8'h09
`define PDF_ADDR_RATE 8'h0A
`define PDF_ADDR_STATUS 8'h0B
`define PDF_ADDR_DUTY_LO 8'h0C
`define PDF_ADDR_DUTY_HI 8'h0D
`define PDF_READ_ZERO 8'h00

// ****************************************
// Fields
// ****************************************
`define PDF_OPT_RAMP_BIT 7
`define PDF_OPT_CURVE_BIT 6
`define PDF_OPT_SCALE_HI 2
`define PDF_OPT_SCALE_LO 0
`define PDF_RATE_RESYNC_BIT 7
`define PDF_RATE_DIV_HI 6
`define PDF_RATE_DIV_LO 0
`define PDF_OPT_RESET 8'h00
`define PDF_RATE_RESET 8'h00

// ****************************************
// Datapath
// ****************************************
`define PDF_DUTY_W 10
`define PDF_DUTY_RESET 10'h000
`define PDF_CALC_W 11
`define PDF_SCALE_MAX 3'h4
`define PDF_LOG_SHIFT 4
`define PDF_DIV_W 7
`define PDF_DIV_RESET 7'h00
`define PDF_DIV_ONE 7'h01

`endif

// file: core/pdf_pkg.sv
/*
 * Types shared by the fade engine files.
 * Assumes pdf_params.svh is on the include path.
 */
`include "pdf_params.svh"

package pdf_pkg;
    typedef logic [`PDF_DUTY_W-1:0] pdf_duty_t;
    typedef logic [`PDF_CALC_W-1:0] pdf_calc_t;
    typedef logic [`PDF_ADDR_W-1:0] pdf_addr_t;
    typedef logic [`PDF_DATA_W-1:0] pdf_data_t;
    // Gray path: idle -> fade -> idle
    typedef enum logic [1:0] {
        PDF_IDLE = 2'b00,
        PDF_FADE = 2'b01
    } pdf_state_t;
endpackage

// file: core/pdf_step.sv
/*
 * Combinational step calculator: next duty one fade update ahead.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/10ps

module pdf_step (
    pdf_step_if.calc sif // Step request and result
);
    import pdf_pkg::*;

    // ****************************************
    // Step size
    // ****************************************
    // Codes above 100 saturate at x16 rather than wrapping
    function automatic pdf_calc_t pdf_scaled(input pdf_calc_t base, input logic [2:0] code);
        logic [2:0] n;
        n = (code > `PDF_SCALE_MAX) ? `PDF_SCALE_MAX : code;
        return base << n;
    endfunction

    pdf_calc_t base_step;
    pdf_calc_t step;
    pdf_calc_t gap;

    always_comb begin
        // R02: log vs linear
        if (sif.curve) begin
            base_step = pdf_calc_t'(1);
        end else if ((sif.cur >> `PDF_LOG_SHIFT) == '0) begin
            // Floor of one keeps a log fade from stalling near zero
            base_step = pdf_calc_t'(1);
        end else begin
            base_step = pdf_calc_t'(sif.cur >> `PDF_LOG_SHIFT);
        end
        // R03: power-of-two scale
        step = pdf_scaled(base_step, sif.scale);
    end

    always_comb begin
        gap = '0;
        // R07: clamp at target
        if (sif.cur < sif.target) begin
            gap = pdf_calc_t'(sif.target) - pdf_calc_t'(sif.cur);
            sif.next = (gap <= step) ? sif.target : pdf_duty_t'(pdf_calc_t'(sif.cur) + step);
        end else begin
            gap = pdf_calc_t'(sif.cur) - pdf_calc_t'(sif.target);
            sif.next = (gap <= step) ? sif.target : pdf_duty_t'(pdf_calc_t'(sif.cur) - step);
        end
    end
endmodule // pdf_step

// file: core/pdf_step_if.sv
/*
 * Carrier between the fade controller and its step calculator.
 * Assumes pdf_pkg is compiled first.
 */
`timescale 1ns/10ps

interface pdf_step_if;
    import pdf_pkg::*;
    pdf_duty_t cur;
    pdf_duty_t target;
    logic curve;
    logic [2:0] scale;
    pdf_duty_t next;
    modport calc (input cur, input target, input curve, input scale, output next);
    modport user (output cur, output target, output curve, output scale, input next);
endinterface

// file: dv/tb_pwm_dimming_fade_engine.sv
/*
 * Self-checking bench for the PWM dimming fade engine top module.
 * Assumes pdf_pkg and the design files are compiled first and that
 * pdf_params.svh is on the include path.
 */
`timescale 1ns/10ps
`include "pdf_params.svh"

module tb_pwm_dimming_fade_engine;
    import pdf_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pdf_addr_t reg_addr = 8'h00;
    pdf_data_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    pdf_data_t reg_rdata;
    logic duty_wr = 1'b0;
    pdf_duty_t duty_wdata = 10'h000;
    logic pwm_period_end = 1'b0;
    logic frame_sync_on = 1'b0;
    logic frame_sync = 1'b0;
    pdf_duty_t duty_out;
    logic fade_busy;
    logic resync_pulse;
    int miscompares = 0;
    int n_tests = 0;
    int cur = 0;
    pdf_data_t rv;

    always #25 clk_sys = ~clk_sys;

    pdf_fade i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .duty_wr(duty_wr),
        .duty_wdata(duty_wdata), .pwm_period_end(pwm_period_end),
        .frame_sync_on(frame_sync_on), .frame_sync(frame_sync), .duty_out(duty_out),
        .fade_busy(fade_busy), .resync_pulse(resync_pulse));

    // ****************************************
    // Compare and bus tasks
    // ****************************************
    task automatic chk_byte(input string what, input pdf_data_t exp, input pdf_data_t got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_duty(input string what, input pdf_duty_t exp, input pdf_duty_t got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input pdf_addr_t a, input pdf_data_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input pdf_addr_t a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task automatic set_duty(input pdf_duty_t v);
        @(posedge clk_sys);
        duty_wdata <= v;
        duty_wr <= 1'b1;
        @(posedge clk_sys);
        duty_wr <= 1'b0;
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs();
        rd(`PDF_ADDR_OPTIONS);
        chk_byte("options reset", `PDF_OPT_RESET, rv);
        rd(`PDF_ADDR_RATE);
        chk_byte("rate reset", `PDF_RATE_RESET, rv);
        wr(`PDF_ADDR_OPTIONS, 8'hFF);
        wr(`PDF_ADDR_RATE, 8'hA5);
        wr(8'h20, 8'h5A);
        rd(`PDF_ADDR_OPTIONS);
        chk_byte("options rw", 8'hC7, rv);
        rd(`PDF_ADDR_RATE);
        chk_byte("rate rw", 8'hA5, rv);
        rd(8'h20);
        chk_byte("unmapped read", 8'h00, rv);
        @(posedge clk_sys);
        #1;
        chk_byte("rdata idle", 8'h00, reg_rdata);
    endtask

    task automatic test_jump();
        wr(`PDF_ADDR_OPTIONS, 8'h47);
        set_duty(10'h155);
        chk_duty("jump duty", 10'h155, duty_out);
        chk_bit("jump busy", 1'b0, fade_busy);
        cur = 'h155;
    endtask

    // Reference fade: one update per (div+1) period ends, clamped at target
    task automatic run_fade(input pdf_data_t opt, input int div, input pdf_duty_t tgt);
        int cnt;
        int base;
        int step;
        int code;
        cnt = 0;
        code = (opt[2:0] > 4) ? 4 : int'(opt[2:0]);
        wr(`PDF_ADDR_OPTIONS, opt);
        wr(`PDF_ADDR_RATE, 8'(div));
        set_duty(tgt);
        chk_bit("busy after write", 1'b1, fade_busy);
        chk_duty("duty held", 10'(cur), duty_out);
        rd(`PDF_ADDR_STATUS);
        chk_bit("status busy", 1'b1, rv[0]);
        for (int i = 0; i < 4000 && cur != tgt; i++) begin
            @(posedge clk_sys);
            pwm_period_end <= 1'b1;
            @(posedge clk_sys);
            pwm_period_end <= 1'b0;
            @(posedge clk_sys);
            #1;
            cnt++;
            if (cnt == div + 1) begin
                cnt = 0;
                base = opt[6] ? 1 : (((cur >> 4) > 1) ? (cur >> 4) : 1);
                step = base << code;
                if (tgt > cur) cur = (tgt - cur <= step) ? int'(tgt) : cur + step;
                else cur = (cur - tgt <= step) ? int'(tgt) : cur - step;
            end
            chk_duty("fade duty", 10'(cur), duty_out);
            chk_bit("fade busy", cur != tgt, fade_busy);
        end
        // A loop limit that runs out shows up here as a mismatch
        chk_duty("fade end", tgt, duty_out);
        chk_bit("fade done", 1'b0, fade_busy);
        rd(`PDF_ADDR_DUTY_LO);
        chk_byte("duty low byte", tgt[7:0], rv);
        rd(`PDF_ADDR_DUTY_HI);
        chk_byte("duty high byte", 8'(tgt[9:8]), rv);
    endtask

    // Pulse needs both the enable level and the resync bit
    task automatic test_resync();
        for (int i = 0; i < 4; i++) begin
            wr(`PDF_ADDR_RATE, i[1] ? 8'h80 : 8'h00);
            @(posedge clk_sys);
            frame_sync_on <= i[0];
            frame_sync <= 1'b1;
            @(posedge clk_sys);
            frame_sync <= 1'b0;
            #1;
            chk_bit("resync pulse", i[0] & i[1], resync_pulse);
            @(posedge clk_sys);
            #1;
            chk_bit("resync one cycle", 1'b0, resync_pulse);
        end
    endtask

    // ****************************************
    // Sequence, verdict and watchdog
    // ****************************************
    task automatic print_verdict();
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        test_regs();
        test_jump();
        for (int c = 0; c < 5; c++) begin
            run_fade(8'hC0 | 8'(c), c, c[0] ? 10'h010 : 10'h3F0);
        end
        run_fade(8'h80, 0, 10'h005);
        run_fade(8'h81, 1, 10'h2A0);
        run_fade(8'hC7, 0, 10'h000);
        test_resync();
        print_verdict();
    end

    // Tests take about 10000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
endmodule // tb_pwm_dimming_fade_engine
